// [rtl/cycle_if.sv]
// Purpose: one memory cycle request between sequencer and pin driver
// Assumes: start is a one-cycle pulse accepted only while the driver idles
// Notes:   done pulses once per cycle, rdata valid with it

`timescale 1ns/1ps
`default_nettype none

interface cycle_if;
   logic        start;
   logic        wr;
   logic [18:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        done;
   logic        idle;

   modport master (output start, wr, addr, wdata,
                   input  rdata, done, idle);
   modport slave  (input  start, wr, addr, wdata,
                   output rdata, done, idle);
endinterface

`default_nettype wire

// [rtl/mem_cycle.sv]
// Purpose: drives the memory pins through one read or write cycle
// Assumes: memory asynchronous, pins sampled on clk_sys
// Notes:   address settles a cycle before any strobe falls

`timescale 1ns/1ps
`default_nettype none

module mem_cycle
   import sram_host_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // request from sequencer
   cycle_if.slave                 cyc,
   // memory pins
   output logic [ADDR_W-1:0]      addr_pins,
   output logic                   cs_n,
   output logic                   oe_n,
   output logic                   store_strobe_n,
   input  wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0]      data_pins_out,
   output logic                   data_pins_oe
);

   typedef enum logic [1:0] {
      C_IDLE   = 2'b00,
      C_SETUP  = 2'b01,
      C_STROBE = 2'b10,
      C_HOLD   = 2'b11
   } cyc_state_t;

   cyc_state_t state_q;
   logic [1:0] cnt_q;
   logic       wr_q;
   logic [7:0] rdata_q;
   logic       done_q;

   // ***********************************************************
   // cycle sequencing
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= C_IDLE;
         cnt_q   <= 2'h0;
      end else begin
         unique case (state_q)
            C_IDLE: begin
               if (cyc.start) begin
                  state_q <= C_SETUP;
               end
            end
            C_SETUP: begin
               state_q <= C_STROBE;
               cnt_q   <= wr_q ? 2'(WPULSE_CYC - 1) : 2'(ACCESS_CYC - 1);
            end
            C_STROBE: begin
               if (cnt_q == 2'h0) begin
                  state_q <= C_HOLD;
                  cnt_q   <= 2'(ADDR_HOLD_CYC - 1);
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            C_HOLD: begin
               if (cnt_q == 2'h0) begin
                  state_q <= C_IDLE;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
         endcase
      end
   end

   // ***********************************************************
   // pin registers
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_pins      <= '0;
         data_pins_out  <= '0;
         wr_q           <= 1'b0;
         cs_n           <= 1'b1;
         oe_n           <= 1'b1;
         store_strobe_n <= 1'b1;
         data_pins_oe   <= 1'b0;
      end else begin
         if (state_q == C_IDLE && cyc.start) begin
            addr_pins     <= cyc.addr;
            data_pins_out <= cyc.wdata;
            wr_q          <= cyc.wr;
         end
         // strobes low only in the strobe phase
         cs_n           <= !(state_q == C_SETUP ||
                             (state_q == C_STROBE && cnt_q != 2'h0));
         oe_n           <= !(!wr_q && (state_q == C_SETUP ||
                             (state_q == C_STROBE && cnt_q != 2'h0)));
         store_strobe_n <= !(wr_q && (state_q == C_SETUP ||
                             (state_q == C_STROBE && cnt_q != 2'h0)));
         // data held through strobe and hold phases
         data_pins_oe   <= wr_q && (state_q == C_SETUP ||
                                    state_q == C_STROBE);
      end
   end

   // ***********************************************************
   // read capture and completion
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
         done_q  <= 1'b0;
      end else begin
         done_q <= (state_q == C_HOLD && cnt_q == 2'h0);
         if (state_q == C_STROBE && cnt_q == 2'h0 && !wr_q) begin
            rdata_q <= data_pins_in;
         end
      end
   end

   assign cyc.rdata = rdata_q;
   assign cyc.done  = done_q;
   assign cyc.idle  = (state_q == C_IDLE);

endmodule

`default_nettype wire

// [rtl/rtc_sram_host.sv]
// Purpose: host controller for a byte-wide battery-backed SRAM with clock
// Assumes: power_good and data_pins_in synchronous to clk_sys
// Notes:   snapshot command reads all clock bytes with updates halted

`timescale 1ns/1ps
`default_nettype none

module rtc_sram_host
   import sram_host_pkg::*;
#(
   parameter int unsigned REC_CYCLES = RECOVERY_CYC
)(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // supply health
   input  wire logic              power_good,
   // user command
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire op_t               cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   // user response
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic [CLOCK_BYTES-1:0][DATA_W-1:0] time_bytes,
   // memory pins
   output logic [ADDR_W-1:0]      addr_pins,
   output logic                   cs_n,
   output logic                   oe_n,
   output logic                   store_strobe_n,
   input  wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0]      data_pins_out,
   output logic                   data_pins_oe
);

   typedef enum logic [2:0] {
      M_IDLE    = 3'b000,
      M_USER    = 3'b001,
      M_RD_CTL  = 3'b010,
      M_SET_HLD = 3'b011,
      M_RD_TIME = 3'b100,
      M_CLR_HLD = 3'b101
   } main_state_t;

   // control byte with the hold bit forced on or off
   function automatic logic [7:0] with_hold(input logic [7:0] ctl,
                                            input logic       on);
      logic [7:0] v;
      v = ctl;
      v[HOLD_SNAP_BIT] = on;
      return v;
   endfunction

   cycle_if     cyc ();
   main_state_t state_q;
   logic [23:0] rec_cnt_q;
   logic        pwr_ok_q;
   logic [7:0]  ctl_q;
   logic [2:0]  idx_q;
   logic        start_q;
   logic        wr_q;
   logic [18:0] addr_q;
   logic [7:0]  wdata_q;

   // ***********************************************************
   // supply watch and recovery wait
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rec_cnt_q <= 24'h000000;
         pwr_ok_q  <= 1'b0;
      end else if (!power_good) begin
         rec_cnt_q <= 24'h000000;
         pwr_ok_q  <= 1'b0;
      end else if (!pwr_ok_q) begin
         if (rec_cnt_q >= 24'(REC_CYCLES - 1)) begin
            pwr_ok_q <= 1'b1;
         end else begin
            rec_cnt_q <= rec_cnt_q + 24'h000001;
         end
      end
   end

   assign cmd_ready = (state_q == M_IDLE) && pwr_ok_q && !start_q &&
                      cyc.idle;

   // ***********************************************************
   // command sequencer
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= M_IDLE;
         start_q <= 1'b0;
         wr_q    <= 1'b0;
         addr_q  <= '0;
         wdata_q <= 8'h00;
         idx_q   <= 3'h0;
      end else begin
         start_q <= 1'b0;
         unique case (state_q)
            M_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  start_q <= 1'b1;
                  if (cmd_op == OP_SNAP) begin
                     state_q <= M_RD_CTL;
                     wr_q    <= 1'b0;
                     addr_q  <= CTRL_ADDR;
                  end else begin
                     state_q <= M_USER;
                     wr_q    <= (cmd_op == OP_WRITE);
                     addr_q  <= cmd_addr;
                     wdata_q <= cmd_wdata;
                  end
               end
            end
            M_USER: begin
               if (cyc.done) begin
                  state_q <= M_IDLE;
               end
            end
            M_RD_CTL: begin
               if (cyc.done) begin
                  // keep calibration bits, only raise hold
                  state_q <= M_SET_HLD;
                  start_q <= 1'b1;
                  wr_q    <= 1'b1;
                  wdata_q <= with_hold(cyc.rdata, 1'b1);
               end
            end
            M_SET_HLD: begin
               if (cyc.done) begin
                  state_q <= M_RD_TIME;
                  start_q <= 1'b1;
                  wr_q    <= 1'b0;
                  idx_q   <= 3'h0;
                  addr_q  <= CLOCK_BASE;
               end
            end
            M_RD_TIME: begin
               if (cyc.done) begin
                  start_q <= 1'b1;
                  if (idx_q == 3'(CLOCK_BYTES - 1)) begin
                     state_q <= M_CLR_HLD;
                     wr_q    <= 1'b1;
                     addr_q  <= CTRL_ADDR;
                     wdata_q <= with_hold(ctl_q, 1'b0);
                  end else begin
                     idx_q  <= idx_q + 3'h1;
                     addr_q <= addr_q + 19'h00001;
                  end
               end
            end
            M_CLR_HLD: begin
               if (cyc.done) begin
                  state_q <= M_IDLE;
               end
            end
            default: begin
               state_q <= M_IDLE;
            end
         endcase
      end
   end

   // ***********************************************************
   // captured data and responses
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctl_q      <= 8'h00;
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
         time_bytes <= '0;
      end else begin
         rsp_valid <= cyc.done &&
                      (state_q == M_USER || state_q == M_CLR_HLD);
         if (cyc.done && state_q == M_RD_CTL) begin
            ctl_q <= cyc.rdata;
         end
         if (cyc.done && state_q == M_USER && !wr_q) begin
            rsp_data <= cyc.rdata;
         end
         if (cyc.done && state_q == M_RD_TIME) begin
            time_bytes[idx_q] <= cyc.rdata;
         end
      end
   end

   assign cyc.start = start_q;
   assign cyc.wr    = wr_q;
   assign cyc.addr  = addr_q;
   assign cyc.wdata = wdata_q;

   // ***********************************************************
   // pin driver
   // ***********************************************************
   mem_cycle u_cycle (
      .clk_sys        (clk_sys),
      .rstn           (rstn),
      .cyc            (cyc.slave),
      .addr_pins      (addr_pins),
      .cs_n           (cs_n),
      .oe_n           (oe_n),
      .store_strobe_n (store_strobe_n),
      .data_pins_in   (data_pins_in),
      .data_pins_out  (data_pins_out),
      .data_pins_oe   (data_pins_oe)
   );

endmodule

`default_nettype wire

// [rtl/sram_host_pkg.sv]
// Purpose: shared constants for the battery-backed clock SRAM host port
// Assumes: 25 MHz system clock, slowest speed grade of the memory
// Notes:   times in ns as printed, cycle counts derived below

package sram_host_pkg;

   // ***********************************************************
   // widths and memory map
   // ***********************************************************
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CLOCK_BYTES = 7;
   localparam logic [18:0] CTRL_ADDR      = 19'h7FFF8;
   localparam logic [18:0] CLOCK_BASE     = 19'h7FFF9;
   localparam int          HOLD_SNAP_BIT  = 6;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_NS        = 40;
   localparam int ACCESS_NS     = 85;   // address / enable to data valid
   localparam int WPULSE_NS     = 65;   // enable low to enable high
   localparam int ADDR_HOLD_NS  = 15;   // enable high to address change
   localparam int RECOVERY_NS   = 1000000;
   localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPULSE_CYC    = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVERY_CYC  = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;

   // ***********************************************************
   // user commands
   // ***********************************************************
   typedef enum logic [1:0] {
      OP_READ  = 2'b00,
      OP_WRITE = 2'b01,
      OP_SNAP  = 2'b10
   } op_t;

endpackage

// [tb/rtc_sram_host_checker.sv]
// Purpose: pin timing and handshake checks for the clock SRAM host
// Assumes: one clock domain, rstn asynchronous active low
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module rtc_sram_host_checker
   import sram_host_pkg::*;
#(
   parameter int unsigned REC_CYCLES = 4
)(
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              rstn,
   // user side
   input wire logic              power_good,
   input wire logic              cmd_valid,
   input wire logic              cmd_ready,
   input wire op_t               cmd_op,
   input wire logic              rsp_valid,
   // memory pins
   input wire logic [ADDR_W-1:0] addr_pins,
   input wire logic              cs_n,
   input wire logic              oe_n,
   input wire logic              store_strobe_n,
   input wire logic [DATA_W-1:0] data_pins_out,
   input wire logic              data_pins_oe
);
   // ****************************************************
   // helper logic, sequences and assertions
   // ****************************************************
   int unsigned pg_run_q;
   logic        accept;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   assign accept = cmd_valid && cmd_ready;
   // cycles in a row with supply good, saturating
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) pg_run_q <= 0;
      else if (!power_good) pg_run_q <= 0;
      else if (pg_run_q < REC_CYCLES) pg_run_q <= pg_run_q + 1;
   end
   sequence read_pulse_s;
      !oe_n [*3] ##1 oe_n;
   endsequence
   sequence write_pulse_s;
      !store_strobe_n [*2] ##1 store_strobe_n;
   endsequence
   read_pulse_a: assert property ($fell(oe_n) |-> read_pulse_s)
      else $error("read strobe width wrong");
   write_pulse_a: assert property (
      $fell(store_strobe_n) |-> write_pulse_s)
      else $error("write strobe width wrong");
   no_contention_a: assert property (
      !(!oe_n && (!store_strobe_n || data_pins_oe)))
      else $error("output enable low during write");
   addr_setup_a: assert property ($fell(cs_n) |-> $stable(addr_pins))
      else $error("address moved as select fell");
   addr_hold_a: assert property (
      $fell(store_strobe_n) |-> $stable(addr_pins) [*3])
      else $error("address moved during write");
   data_hold_a: assert property (
      $fell(store_strobe_n) |-> (data_pins_oe && $stable(data_pins_out)) [*3])
      else $error("write data not held");
   idle_gap_a: assert property ($rose(cs_n) |=> cs_n)
      else $error("no idle cycle between accesses");
   read_lat_a: assert property (
      accept && cmd_op != OP_WRITE && cmd_op != OP_SNAP |-> ##8 rsp_valid)
      else $error("read response late or early");
   write_lat_a: assert property (
      accept && cmd_op == OP_WRITE |-> ##7 rsp_valid)
      else $error("write response late or early");
   power_drop_a: assert property (!power_good |=> !cmd_ready)
      else $error("ready while supply bad");
   recovery_wait_a: assert property (
      cmd_ready |-> pg_run_q == REC_CYCLES)
      else $error("ready before recovery delay");
endmodule
bind rtc_sram_host rtc_sram_host_checker #(.REC_CYCLES(REC_CYCLES)) pin_check (
   .clk_sys, .rstn, .power_good, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid,
   .addr_pins, .cs_n, .oe_n, .store_strobe_n, .data_pins_out, .data_pins_oe);
`default_nettype wire

// [tb/sram_rtc_model.sv]
// Purpose: behavioural battery-backed SRAM with clock bytes
// Assumes: one tick of the time counter is a scaled second
// Notes:   released data pins show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module sram_rtc_model
   import sram_host_pkg::*;
#(
   parameter int REC_NS   = 100,
   parameter int TICK_DIV = 100,
   parameter int HOLD_NS  = 5
)(
   // memory pins from the host
   input  wire logic [ADDR_W-1:0] addr_pins,
   input  wire logic              cs_n,
   input  wire logic              oe_n,
   input  wire logic              store_strobe_n,
   input  wire logic [DATA_W-1:0] host_data,
   input  wire logic              power_good,
   // byte the memory puts on the data pins
   output logic [DATA_W-1:0]      mem_dq
);
   // ****************************************************
   // storage, supply, clock copies and data pins
   // ****************************************************
   localparam logic [7:0] CAL [6] = '{8'h30, 8'h12, 8'h03, 8'h15, 8'h06, 8'h24};
   logic [7:0] mem [int];
   logic [7:0] last_q = 8'h00;
   logic [7:0] rd_byte = 8'h00;
   logic       pwr = 1'b1;
   logic       wr_act = 1'b0;
   logic       hold = 1'b0;
   int         secs = 0;
   int         sub = 0;
   // calendar bytes above seconds, 24-hour bcd
   initial begin
      mem[int'(CTRL_ADDR)] = 8'h00;
      mem[int'(CLOCK_BASE)] = 8'h00;
      for (int i = 0; i < 6; i++) mem[int'(CLOCK_BASE) + 1 + i] = CAL[i];
   end
   // supply monitor with recovery delay
   always @(power_good) begin
      if (!power_good) pwr = 1'b0;
      else begin
         #(REC_NS);
         pwr = power_good;
      end
   end
   // write window from later fall to earlier rise
   always @(negedge cs_n or negedge store_strobe_n)
      wr_act = pwr && !cs_n && !store_strobe_n;
   always @(posedge cs_n or posedge store_strobe_n) begin
      if (wr_act && pwr) begin
         mem[int'(addr_pins)] = host_data;
         if (addr_pins == CTRL_ADDR) begin
            if (hold && !host_data[HOLD_SNAP_BIT]) sub = 0;
            hold = host_data[HOLD_SNAP_BIT];
         end
      end
      wr_act = 1'b0;
   end
   // time counter runs always, copies only when not held
   always begin
      #100;
      sub = sub + 1;
      if (sub >= TICK_DIV) begin
         sub = 0;
         secs = secs + 1;
         if (!hold) mem[int'(CLOCK_BASE)] = 8'((secs % 60 / 10) * 16 + secs % 10);
      end
   end
   // drive only on a read with both enables low, garbage until access time
   always @(addr_pins or cs_n or oe_n or store_strobe_n or pwr) begin
      if (pwr && !cs_n && !oe_n && store_strobe_n) begin
         rd_byte = mem.exists(int'(addr_pins)) ? mem[int'(addr_pins)]
                                               : ~last_q;
         mem_dq <= #(HOLD_NS) ~rd_byte;
         mem_dq <= #(ACCESS_NS) rd_byte;
         last_q = rd_byte;
      end
      else mem_dq <= ~last_q;
   end
endmodule
`default_nettype wire

// [tb/tb_rtc_sram_host.sv]
// Purpose: self-checking bench for the clock SRAM host
// Assumes: memory model on the far side, supply driven here
// Notes:   recovery shortened to four cycles
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_sram_host
   import sram_host_pkg::*;
;
   // ****************************************************
   // signals, instances and tasks
   // ****************************************************
   localparam int REC = 4;
   localparam logic [18:0] ADDRS [5] = '{19'h00000, 19'h00001, 19'h40000,
                                         19'h7FFF7, 19'h2AAAA};
   localparam logic [7:0] CAL [6] = '{8'h30, 8'h12, 8'h03, 8'h15, 8'h06, 8'h24};
   logic                  clk_sys = 1'b0, rstn = 1'b0, power_good = 1'b1;
   logic                  cmd_valid = 1'b0, cmd_ready, rsp_valid, data_pins_oe;
   logic                  cs_n, oe_n, store_strobe_n;
   op_t                   cmd_op = OP_READ;
   logic [ADDR_W-1:0]     cmd_addr = '0, addr_pins;
   logic [DATA_W-1:0]     cmd_wdata = '0, rsp_data, mem_dq, rd;
   logic [DATA_W-1:0]     data_pins_in, data_pins_out;
   logic [CLOCK_BYTES-1:0][DATA_W-1:0] time_bytes;
   int                    err_count = 0, total_checks = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   assign data_pins_in = data_pins_oe ? data_pins_out : mem_dq;
   rtc_sram_host #(.REC_CYCLES(REC)) dut (.clk_sys, .rstn, .power_good,
      .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid,
      .rsp_data, .time_bytes, .addr_pins, .cs_n, .oe_n, .store_strobe_n,
      .data_pins_in, .data_pins_out, .data_pins_oe);
   sram_rtc_model mdl (.addr_pins, .cs_n, .oe_n, .store_strobe_n,
      .host_data(data_pins_out), .power_good, .mem_dq);
   task automatic chk(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // falling edges until the command port is ready, bounded
   task automatic wait_ready(output int n);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      chk("ready seen", {7'h00, cmd_ready}, 8'h01);
   endtask
   // one command held until taken, then the response byte
   task automatic run_cmd(input op_t op, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      wait_ready(n);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      chk("response seen", {7'h00, rsp_valid}, 8'h01);
      rd = rsp_data;
   endtask
   // boundary addresses written, then read back to back
   task automatic t_rw;
      for (int i = 0; i < 5; i++) run_cmd(OP_WRITE, ADDRS[i], 8'hA0 + 8'(i));
      for (int i = 0; i < 5; i++) begin
         run_cmd(i == 4 ? op_t'(2'b11) : OP_READ, ADDRS[i], 8'h00);
         chk("read back", rd, 8'hA0 + 8'(i));
      end
   endtask
   // hold bit freezes seconds, clearing it restarts the second
   task automatic t_hold;
      logic [7:0] s1;
      run_cmd(OP_WRITE, CTRL_ADDR, 8'h40);
      run_cmd(OP_READ, CLOCK_BASE, 8'h00);
      s1 = rd;
      repeat (600) @(negedge clk_sys);
      run_cmd(OP_READ, CLOCK_BASE, 8'h00);
      chk("frozen seconds", rd, s1);
      run_cmd(OP_WRITE, CTRL_ADDR, 8'h00);
      run_cmd(OP_READ, CLOCK_BASE, 8'h00);
      chk("no early refresh", rd, s1);
      repeat (300) @(negedge clk_sys);
      run_cmd(OP_READ, CLOCK_BASE, 8'h00);
      chk("refreshed seconds", rd, 8'((mdl.secs % 60 / 10) * 16 + mdl.secs % 10));
   endtask
   // snapshot keeps the other control bits
   task automatic t_snap;
      run_cmd(OP_WRITE, CTRL_ADDR, 8'h25);
      run_cmd(OP_SNAP, '0, 8'h00);
      chk("seconds byte", time_bytes[0], mdl.mem[int'(CLOCK_BASE)]);
      for (int i = 1; i < 7; i++) chk("calendar byte", time_bytes[i], CAL[i-1]);
      run_cmd(OP_READ, CTRL_ADDR, 8'h00);
      chk("control restored", rd, 8'h25);
   endtask
   // supply dip in mid-write, then recovery
   task automatic t_power_fail;
      int n;
      fork
         run_cmd(OP_WRITE, 19'h12345, 8'hC3);
         begin
            repeat (3) @(negedge clk_sys);
            power_good = 1'b0;
         end
      join
      chk("ready in fail", {7'h00, cmd_ready}, 8'h00);
      repeat (4) @(negedge clk_sys);
      power_good = 1'b1;
      wait_ready(n);
      chk("ready delay", 8'(n), 8'(REC));
      run_cmd(OP_READ, ADDRS[0], 8'h00);
      chk("other byte", rd, 8'hA0);
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         report_and_stop;
      end
   end
   // main sequence
   initial begin
      int n;
      repeat (2) @(negedge clk_sys);
      rstn = 1'b1;
      wait_ready(n);
      chk("ready after reset", 8'(n), 8'(REC));
      t_rw;
      t_hold;
      t_snap;
      t_power_fail;
      report_and_stop;
   end
endmodule
`default_nettype wire
